// >>> rtl/omc_pkg.sv
// Package of timing constants and state codes for the module controller
//------------------------------------------------------------------------
// Operation
// - Disable rise drops laser within 100 us
// - Normal-mode enable settles within 2 ms
// - 2 ms limit excludes start-up and recovery
// - Two-wire interface ready within 300 ms
// - Non-cooled part operational within 300 ms
// - Cooled part operational within 90 s
// - Power level II reached within 300 ms
// - Back to level I power within 300 ms
// - Fault output within 1 ms / 50 ms
// - Disable held 10 us resets the fault
// - Fibre Channel rate change stable in 500 us
// - Other rate change stable in 10 ms
// - Loss-of-signal asserted within 100 us
// - Loss-of-signal negated within 100 us
//------------------------------------------------------------------------
package omc_pkg;

  // Counter width: 90 s at 200 MHz needs 35 bits
  localparam int unsigned CNT_W = 36;
  typedef logic [CNT_W-1:0] omc_cnt_t;

  // Clock rate and unit scaling
  localparam longint unsigned CLK_HZ     = 64'd200000000;
  localparam longint unsigned CYC_PER_US = CLK_HZ / 64'd1000000;
  localparam longint unsigned CYC_PER_MS = CLK_HZ / 64'd1000;
  localparam longint unsigned CYC_PER_S  = CLK_HZ;

  // Times as printed
  localparam longint unsigned T_OFF_US          = 64'd100;
  localparam longint unsigned T_ON_MS           = 64'd2;
  localparam longint unsigned T_2W_MS           = 64'd300;
  localparam longint unsigned T_START_MS        = 64'd300;
  localparam longint unsigned T_START_COOLED_S  = 64'd90;
  localparam longint unsigned T_PL2_MS          = 64'd300;
  localparam longint unsigned T_PDN_MS          = 64'd300;
  localparam longint unsigned T_FAULT_ON_MS     = 64'd1;
  localparam longint unsigned T_FAULT_COOLED_MS = 64'd50;
  localparam longint unsigned T_RESET_US        = 64'd10;
  localparam longint unsigned T_RS_FC_US        = 64'd500;
  localparam longint unsigned T_RS_MS           = 64'd10;
  localparam longint unsigned T_LOS_US          = 64'd100;

  // Cycle counts: longest times round down, least times round up
  localparam omc_cnt_t T_OFF_CYC   = omc_cnt_t'(T_OFF_US * CYC_PER_US);
  localparam omc_cnt_t T_ON_CYC    = omc_cnt_t'(T_ON_MS * CYC_PER_MS);
  localparam omc_cnt_t T_2W_CYC    = omc_cnt_t'(T_2W_MS * CYC_PER_MS);
  localparam omc_cnt_t T_START_CYC = omc_cnt_t'(T_START_MS * CYC_PER_MS);
  localparam omc_cnt_t T_START_COOLED_CYC =
    omc_cnt_t'(T_START_COOLED_S * CYC_PER_S);
  localparam omc_cnt_t T_PL2_CYC   = omc_cnt_t'(T_PL2_MS * CYC_PER_MS);
  localparam omc_cnt_t T_PDN_CYC   = omc_cnt_t'(T_PDN_MS * CYC_PER_MS);
  localparam omc_cnt_t T_FAULT_ON_CYC =
    omc_cnt_t'(T_FAULT_ON_MS * CYC_PER_MS);
  localparam omc_cnt_t T_FAULT_COOLED_CYC =
    omc_cnt_t'(T_FAULT_COOLED_MS * CYC_PER_MS);
  localparam omc_cnt_t T_RESET_CYC =
    omc_cnt_t'((T_RESET_US * CLK_HZ + 64'd999999) / 64'd1000000);
  localparam omc_cnt_t T_RS_FC_CYC = omc_cnt_t'(T_RS_FC_US * CYC_PER_US);
  localparam omc_cnt_t T_RS_CYC    = omc_cnt_t'(T_RS_MS * CYC_PER_MS);
  localparam omc_cnt_t T_LOS_CYC   = omc_cnt_t'(T_LOS_US * CYC_PER_US);

  // Default two-wire bring-up delay, well inside its budget
  localparam omc_cnt_t TW_INIT_CYC = 36'h000000400;

  // Transmitter sequencing states
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_START = 4'h2,
    ST_RUN   = 4'h4,
    ST_FAULT = 4'h8
  } omc_tx_state_e;

endpackage

// >>> rtl/omc_edge.sv
// Edge detector on a synchronous level input
`timescale 1ns/1ps
module omc_edge (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Level in, edges out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_q;
  logic prev_d;

  //----------------------------------------------------------------------
  // Previous level
  //----------------------------------------------------------------------
  // Reset value high so an input that starts high is not seen as a rise
  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Edges compare the live level against last cycle
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule // omc_edge

// >>> rtl/omc_timer.sv
// One-shot down-counting timer with a run-time limit
`timescale 1ns/1ps
module omc_timer #(
  parameter int unsigned W = 36
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              running,
  output logic              expired
);

  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d;
  logic         exp_q, exp_d;

  //----------------------------------------------------------------------
  // Count
  //----------------------------------------------------------------------
  // Expired rises limit cycles after start and holds until restarted or aborted
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = exp_q;
    if (abort) begin
      run_d = 1'b0;
      exp_d = 1'b0;
    end else if (start) begin
      cnt_d = (limit == '0) ? '0 : limit - W'(1);
      run_d = 1'b1;
      exp_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign running = run_q;
  assign expired = exp_q;

endmodule // omc_timer

// >>> rtl/omc_ctrl.sv
// Transmitter, fault, rate, power level and loss-of-signal sequencer
`timescale 1ns/1ps
module omc_ctrl #(
  parameter bit                COOLED         = 1'b0,
  parameter omc_pkg::omc_cnt_t T_ON_CYC       = omc_pkg::T_ON_CYC,
  parameter omc_pkg::omc_cnt_t T_START_CYC    = omc_pkg::T_START_CYC,
  parameter omc_pkg::omc_cnt_t T_START_COOLED_CYC =
    omc_pkg::T_START_COOLED_CYC,
  parameter omc_pkg::omc_cnt_t T_2W_CYC       = omc_pkg::T_2W_CYC,
  parameter omc_pkg::omc_cnt_t TW_INIT_CYC    = omc_pkg::TW_INIT_CYC,
  parameter omc_pkg::omc_cnt_t T_PL2_CYC      = omc_pkg::T_PL2_CYC,
  parameter omc_pkg::omc_cnt_t T_PDN_CYC      = omc_pkg::T_PDN_CYC,
  parameter omc_pkg::omc_cnt_t T_RS_FC_CYC    = omc_pkg::T_RS_FC_CYC,
  parameter omc_pkg::omc_cnt_t T_RS_CYC       = omc_pkg::T_RS_CYC
) (
  // Clock and reset (reset is supply valid / hot plug)
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Host control pins
  input  wire logic       tx_disable,
  input  wire logic       rate_select_zero,
  input  wire logic       rate_select_one,
  input  wire logic       fc_mode,
  // Host status pins, open drain
  output logic            tx_fault_o,
  output logic            tx_fault_oe_n,
  output logic            rx_los_o,
  output logic            rx_los_oe_n,
  // Management side
  input  wire logic       pl2_on_stop,
  input  wire logic       pl2_off_stop,
  output logic            twowire_ready,
  output logic            pl2_active,
  output logic            pl2_timeout,
  // Optical front end
  input  wire logic       laser_fault_raw,
  input  wire logic       apc_settled,
  input  wire logic       rx_signal_detect,
  input  wire logic       cdr_locked,
  input  wire logic       pl2_power_good,
  output logic            laser_enable,
  output logic            pl2_supply_en,
  output logic [1:0]      rate_cfg,
  output logic            rate_stable,
  output logic            module_ready,
  output logic            startup_late
);

  localparam int unsigned W = omc_pkg::CNT_W;

  omc_pkg::omc_tx_state_e st_q, st_d;
  logic norm_q, norm_d;          // set once start-up has completed
  logic late_q, late_d;
  logic fault_q, fault_d;
  logic laser_q, laser_d;
  logic boot_q, boot_d;
  logic tw_q, tw_d;
  logic los_q, los_d;
  logic [1:0] rate_q, rate_d;
  logic stable_q, stable_d;
  logic pl2_en_q, pl2_en_d;
  logic pl2_act_q, pl2_act_d;
  logic pl2_to_q, pl2_to_d;
  logic dis_rise, dis_fall, rs0_rise, rs1_rise, rs_rise;
  logic bud_start, bud_exp, rst_exp, tw_exp, rs_exp, pl_exp, pl_run;
  logic [W-1:0] bud_lim, rs_lim, pl_lim;

  //----------------------------------------------------------------------
  // Edge detection on host pins
  //----------------------------------------------------------------------
  omc_edge u_dis_edge (.sys_clk(sys_clk), .rst_n(rst_n),
    .level(tx_disable), .rise(dis_rise), .fall(dis_fall));
  omc_edge u_rs0_edge (.sys_clk(sys_clk), .rst_n(rst_n),
    .level(rate_select_zero), .rise(rs0_rise), .fall());
  omc_edge u_rs1_edge (.sys_clk(sys_clk), .rst_n(rst_n),
    .level(rate_select_one), .rise(rs1_rise), .fall());
  assign rs_rise = rs0_rise | rs1_rise;

  //----------------------------------------------------------------------
  // Timers
  //----------------------------------------------------------------------
  // Bring-up budget: the short enable limit only after a normal start
  assign bud_lim = norm_q ? T_ON_CYC
                 : (COOLED ? T_START_COOLED_CYC : T_START_CYC);
  assign bud_start = (st_d == omc_pkg::ST_START)
                   && (st_q != omc_pkg::ST_START);
  // Abort on the next state, else entry into start-up cancels the load
  omc_timer #(.W(W)) u_bud_tmr (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(bud_start), .abort(st_d != omc_pkg::ST_START),
    .limit(bud_lim), .running(), .expired(bud_exp));

  // Disable-high width measure; an early fall aborts it
  omc_timer #(.W(W)) u_rst_tmr (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(dis_rise), .abort(dis_fall),
    .limit(omc_pkg::T_RESET_CYC), .running(), .expired(rst_exp));

  // Two-wire bring-up runs once after reset
  omc_timer #(.W(W)) u_tw_tmr (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(!boot_q), .abort(1'b0),
    .limit(TW_INIT_CYC), .running(), .expired(tw_exp));

  // Rate change settling budget depends on the protocol
  assign rs_lim = fc_mode ? T_RS_FC_CYC : T_RS_CYC;
  omc_timer #(.W(W)) u_rs_tmr (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(rs_rise), .abort(1'b0),
    .limit(rs_lim), .running(), .expired(rs_exp));

  // Power level change budget
  assign pl_lim = pl2_on_stop ? T_PL2_CYC : T_PDN_CYC;
  omc_timer #(.W(W)) u_pl_tmr (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(pl2_on_stop | pl2_off_stop), .abort(1'b0),
    .limit(pl_lim), .running(pl_run), .expired(pl_exp));

  //----------------------------------------------------------------------
  // Transmitter sequencer
  //----------------------------------------------------------------------
  // Fault beats everything but is latched only while the laser is on
  always_comb begin
    st_d   = st_q;
    norm_d = norm_q;
    late_d = late_q;
    case (st_q)
      omc_pkg::ST_OFF: begin
        if (!tx_disable) begin
          st_d = omc_pkg::ST_START;
        end
      end
      omc_pkg::ST_START: begin
        if (laser_fault_raw) begin
          st_d = omc_pkg::ST_FAULT;
        end else if (tx_disable) begin
          st_d = omc_pkg::ST_OFF;
        end else if (apc_settled) begin
          st_d   = omc_pkg::ST_RUN;
          norm_d = 1'b1;
        end else if (bud_exp) begin
          st_d   = omc_pkg::ST_FAULT;
          late_d = 1'b1;
        end
      end
      omc_pkg::ST_RUN: begin
        if (laser_fault_raw) begin
          st_d = omc_pkg::ST_FAULT;
        end else if (tx_disable) begin
          st_d = omc_pkg::ST_OFF;
        end
      end
      omc_pkg::ST_FAULT: begin
        // Recovery is a fresh start-up with the long budget
        if (tx_disable && rst_exp) begin
          st_d   = omc_pkg::ST_OFF;
          norm_d = 1'b0;
          late_d = 1'b0;
        end
      end
      default: begin
        st_d = omc_pkg::ST_OFF;
      end
    endcase
    fault_d = (st_d == omc_pkg::ST_FAULT);
    laser_d = (st_d == omc_pkg::ST_START) || (st_d == omc_pkg::ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= omc_pkg::ST_OFF;
      norm_q  <= 1'b0;
      late_q  <= 1'b0;
      fault_q <= 1'b0;
      laser_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      norm_q  <= norm_d;
      late_q  <= late_d;
      fault_q <= fault_d;
      laser_q <= laser_d;
    end
  end

  //----------------------------------------------------------------------
  // Two-wire readiness, rate select, power level, loss of signal
  //----------------------------------------------------------------------
  // Rate stable waits for lock or gives up at the deadline
  always_comb begin
    boot_d   = 1'b1;
    tw_d     = tw_q | tw_exp;
    los_d    = ~rx_signal_detect;
    rate_d   = {rate_select_one, rate_select_zero};
    stable_d = stable_q;
    if (rs_rise) begin
      stable_d = 1'b0;
    end else if (!stable_q && (cdr_locked || rs_exp)) begin
      stable_d = 1'b1;
    end
    pl2_en_d = pl2_en_q;
    if (pl2_on_stop) begin
      pl2_en_d = 1'b1;
    end else if (pl2_off_stop) begin
      pl2_en_d = 1'b0;
    end
    pl2_act_d = pl2_en_q & pl2_power_good;
    // Timeout flags a supply that missed its window; next command clears,
    // but a miss seen in the same cycle as a command is not lost
    pl2_to_d = pl2_to_q;
    if (pl_exp && (pl2_en_q != pl2_power_good)) begin
      pl2_to_d = 1'b1;
    end else if (pl2_on_stop || pl2_off_stop) begin
      pl2_to_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q    <= 1'b0;
      tw_q      <= 1'b0;
      los_q     <= 1'b1;
      rate_q    <= 2'h0;
      stable_q  <= 1'b0;
      pl2_en_q  <= 1'b0;
      pl2_act_q <= 1'b0;
      pl2_to_q  <= 1'b0;
    end else begin
      boot_q    <= boot_d;
      tw_q      <= tw_d;
      los_q     <= los_d;
      rate_q    <= rate_d;
      stable_q  <= stable_d;
      pl2_en_q  <= pl2_en_d;
      pl2_act_q <= pl2_act_d;
      pl2_to_q  <= pl2_to_d;
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  // Open drain: released (high) means asserted, pulled up by the host
  assign tx_fault_o    = 1'b0;
  assign tx_fault_oe_n = fault_q;
  assign rx_los_o      = 1'b0;
  assign rx_los_oe_n   = los_q;
  assign laser_enable  = laser_q;
  assign twowire_ready = tw_q;
  assign rate_cfg      = rate_q;
  assign rate_stable   = stable_q;
  assign pl2_supply_en = pl2_en_q;
  assign pl2_active    = pl2_act_q;
  assign pl2_timeout   = pl2_to_q;
  assign module_ready  = (st_q == omc_pkg::ST_RUN);
  assign startup_late  = late_q;

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  // Helper counters: cycles from reset until two-wire ready, cycles disable held high
  logic [W-1:0] up_cnt_q;
  logic [11:0]  hi_cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_q <= '0;
      hi_cnt_q <= 12'h000;
    end else begin
      up_cnt_q <= tw_q ? up_cnt_q : up_cnt_q + W'(1);
      hi_cnt_q <= !tx_disable ? 12'h000
                : (hi_cnt_q == 12'hfff ? hi_cnt_q : hi_cnt_q + 12'h001);
    end
  end

  AST_TX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_disable |=> !laser_enable)
    else $error("laser still on after disable");
  AST_ON_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bud_start && norm_q |-> bud_lim == T_ON_CYC)
    else $error("normal enable budget wrong");
  AST_START_LIMIT: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    bud_start && !norm_q |-> bud_lim ==
      (COOLED ? T_START_COOLED_CYC : T_START_CYC))
    else $error("start-up budget wrong");
  AST_TW_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !twowire_ready |-> up_cnt_q < T_2W_CYC)
    else $error("two-wire interface late");
  AST_FAULT_ON: assert property (@(posedge sys_clk) disable iff (!rst_n)
    laser_fault_raw && laser_enable |=> tx_fault_oe_n)
    else $error("fault not reported");
  AST_FAULT_RESET: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $fell(tx_fault_oe_n) |-> 36'(hi_cnt_q) >= omc_pkg::T_RESET_CYC)
    else $error("fault cleared by short pulse");
  AST_FAULT_HOLD: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    tx_fault_oe_n && !tx_disable |=> tx_fault_oe_n && !laser_enable)
    else $error("fault dropped without reset pulse");
  AST_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rs_rise |=> !rate_stable ##0 rate_cfg == $past({rate_select_one,
      rate_select_zero}))
    else $error("rate change not tracked");
  AST_RATE_LIMIT: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rs_rise && !fc_mode |-> rs_lim == T_RS_CYC)
    else $error("rate budget wrong");
  AST_LOS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rx_signal_detect [*2] |-> rx_los_oe_n)
    else $error("loss of signal not raised");
  AST_LOS_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rx_signal_detect) |=> !rx_los_oe_n)
    else $error("loss of signal not cleared");
  AST_PL2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pl2_on_stop |=> pl2_supply_en && pl_run)
    else $error("level II not started");
  AST_PL1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pl2_off_stop && !pl2_on_stop |=> !pl2_supply_en ##1 !pl2_active)
    else $error("level II not left");

endmodule // omc_ctrl

// >>> sim/omc_far_model.sv
// Optical front end and host pull-up model around the controller
`timescale 1ns/1ps
module omc_far_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Scenario controls
  input  wire logic       slow,
  input  wire logic       cdr_hold,
  // From the controller
  input  wire logic       laser_enable,
  input  wire logic       pl2_supply_en,
  input  wire logic [1:0] rate_cfg,
  input  wire logic       tx_fault_o,
  input  wire logic       tx_fault_oe_n,
  input  wire logic       rx_los_o,
  input  wire logic       rx_los_oe_n,
  // To the controller and host
  output logic            apc_settled,
  output logic            cdr_locked,
  output logic            pl2_power_good,
  output logic            tx_fault_pin,
  output logic            rx_los_pin
);
  logic [7:0] apc_q;
  logic [2:0] cdr_q;
  logic [1:0] rate_q;
  logic [2:0] pg_q;

  // Power loop, lock and supply ramps; slow loop outlasts a normal budget
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apc_q  <= 8'h00;
      cdr_q  <= 3'h0;
      rate_q <= 2'h0;
      pg_q   <= 3'h0;
    end else begin
      apc_q  <= !laser_enable ? 8'h00
              : (apc_q == 8'hff ? apc_q : apc_q + 8'h01);
      rate_q <= rate_cfg;
      cdr_q  <= (rate_cfg != rate_q) ? 3'h0
              : (cdr_q == 3'h4 ? cdr_q : cdr_q + 3'h1);
      pg_q   <= {pg_q[1:0], pl2_supply_en};
    end
  end

  // Settle time follows the laser, lock is lost at once on a rate change
  assign apc_settled    = laser_enable && (apc_q >= (slow ? 8'h96 : 8'h05));
  assign cdr_locked     = !cdr_hold && (rate_cfg == rate_q) && (cdr_q == 3'h4);
  assign pl2_power_good = pg_q[2];
  // Open drain pins with host pull-ups: released means high
  assign tx_fault_pin   = tx_fault_oe_n ? 1'b1 : tx_fault_o;
  assign rx_los_pin     = rx_los_oe_n ? 1'b1 : rx_los_o;
endmodule // omc_far_model

// >>> sim/optical_module_ctrl_status_bench.sv
// Self-checking bench for the module control and status sequencer
`timescale 1ns/1ps
module optical_module_ctrl_status_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0, tx_disable = 1'b0, fc_mode = 1'b0;
  logic rate_select_zero = 1'b0, rate_select_one = 1'b0;
  logic pl2_on_stop = 1'b0, pl2_off_stop = 1'b0, laser_fault_raw = 1'b0;
  logic rx_signal_detect = 1'b1, slow = 1'b0, cdr_hold = 1'b0;
  logic tx_fault_o, tx_fault_oe_n, rx_los_o, rx_los_oe_n, twowire_ready;
  logic pl2_active, pl2_timeout, apc_settled, cdr_locked, pl2_power_good;
  logic laser_enable, pl2_supply_en, rate_stable, module_ready, startup_late;
  logic tx_fault_pin, rx_los_pin;
  logic [1:0] rate_cfg;
  int error_cnt = 0, total_checks = 0, budget;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Enable, start-up and rate budgets and the two-wire bring-up delay are shortened; power level budgets keep their defaults
  omc_ctrl #(.T_ON_CYC(36'h64), .T_START_CYC(36'hc8), .TW_INIT_CYC(36'h14),
    .T_RS_FC_CYC(36'h32), .T_RS_CYC(36'h64)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .tx_disable(tx_disable), .rate_select_zero(rate_select_zero),
    .rate_select_one(rate_select_one), .fc_mode(fc_mode),
    .tx_fault_o(tx_fault_o), .tx_fault_oe_n(tx_fault_oe_n),
    .rx_los_o(rx_los_o), .rx_los_oe_n(rx_los_oe_n),
    .pl2_on_stop(pl2_on_stop), .pl2_off_stop(pl2_off_stop),
    .twowire_ready(twowire_ready), .pl2_active(pl2_active),
    .pl2_timeout(pl2_timeout), .laser_fault_raw(laser_fault_raw),
    .apc_settled(apc_settled), .rx_signal_detect(rx_signal_detect),
    .cdr_locked(cdr_locked), .pl2_power_good(pl2_power_good),
    .laser_enable(laser_enable), .pl2_supply_en(pl2_supply_en),
    .rate_cfg(rate_cfg), .rate_stable(rate_stable),
    .module_ready(module_ready), .startup_late(startup_late));

  omc_far_model i_far (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .cdr_hold(cdr_hold), .laser_enable(laser_enable),
    .pl2_supply_en(pl2_supply_en), .rate_cfg(rate_cfg),
    .tx_fault_o(tx_fault_o), .tx_fault_oe_n(tx_fault_oe_n),
    .rx_los_o(rx_los_o), .rx_los_oe_n(rx_los_oe_n),
    .apc_settled(apc_settled), .cdr_locked(cdr_locked),
    .pl2_power_good(pl2_power_good), .tx_fault_pin(tx_fault_pin),
    .rx_los_pin(rx_los_pin));

  // Inputs move on falling edges, so every sample here is settled
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic expect_now(input logic act, input logic exp, input string msg);
    total_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait; a miss is reported like any other mismatch
  task automatic expect_within(ref logic s, input logic v, input int lim,
                               input string msg);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      cyc(1);
      n++;
    end
    expect_now(s, v, msg);
  endtask

  task automatic fault_reset();
    tx_disable = 1'b1;
    cyc(2010);
    expect_now(tx_fault_pin, 1'b0, "fault not cleared by long pulse");
    tx_disable = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the tests take roughly 6k cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    $display("FAIL at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    cyc(3);
    expect_now(laser_enable, 1'b0, "laser on in reset");
    expect_now(tx_fault_pin, 1'b0, "fault pin high in reset");
    expect_now(rx_los_pin, 1'b1, "los pin low in reset");
    expect_now(twowire_ready, 1'b0, "two-wire ready in reset");
    rst_n = 1'b1;
    expect_within(module_ready, 1'b1, 200, "start-up late");
    expect_within(twowire_ready, 1'b1, 300, "two-wire late");
    $display("test startup done");

    tx_disable = 1'b1;
    expect_within(laser_enable, 1'b0, 2, "laser still on");
    cyc(20);
    tx_disable = 1'b0;
    expect_within(module_ready, 1'b1, 100, "enable late");
    $display("test disable done");

    // Normal enable with a slow loop misses its budget and faults
    slow = 1'b1;
    tx_disable = 1'b1;
    cyc(5);
    tx_disable = 1'b0;
    expect_within(tx_fault_pin, 1'b1, 110, "missed budget not flagged");
    expect_now(startup_late, 1'b1, "late flag missing");
    cyc(50);
    expect_now(tx_fault_pin, 1'b1, "fault not sticky");
    expect_now(laser_enable, 1'b0, "laser on in fault");
    tx_disable = 1'b1;
    cyc(1000);
    tx_disable = 1'b0;
    cyc(10);
    expect_now(tx_fault_pin, 1'b1, "short pulse cleared fault");
    fault_reset();
    expect_within(module_ready, 1'b1, 200, "recovery late");
    expect_now(tx_fault_pin, 1'b0, "recovery held to normal budget");
    slow = 1'b0;
    $display("test budget done");

    laser_fault_raw = 1'b1;
    expect_within(tx_fault_pin, 1'b1, 2, "fault not reported");
    expect_now(laser_enable, 1'b0, "laser on after fault");
    laser_fault_raw = 1'b0;
    fault_reset();
    expect_within(module_ready, 1'b1, 200, "restart late");
    $display("test fault done");

    // Both selects in both modes; held lock exercises the budget expiry
    for (int m = 0; m < 4; m++) begin
      fc_mode = m[1];
      cdr_hold = m[0];
      budget = m[1] ? 50 : 100;
      rate_select_zero = !m[0];
      rate_select_one = m[0];
      cyc(2);
      expect_now(rate_stable, 1'b0, "rate still stable");
      expect_now(rate_cfg[0], !m[0], "rate select zero not applied");
      expect_now(rate_cfg[1], m[0], "rate select one not applied");
      if (m[0])
        cyc(budget - 5);
      if (m[0])
        expect_now(rate_stable, 1'b0, "stable before lock");
      expect_within(rate_stable, 1'b1, budget, "rate late");
      rate_select_zero = 1'b0;
      rate_select_one = 1'b0;
      cyc(budget + 5);
    end
    cdr_hold = 1'b0;
    $display("test rate done");

    rx_signal_detect = 1'b0;
    expect_within(rx_los_pin, 1'b1, 2, "los not asserted");
    cyc(3);
    expect_now(rx_los_pin, 1'b1, "los dropped while dark");
    rx_signal_detect = 1'b1;
    expect_within(rx_los_pin, 1'b0, 2, "los not negated");
    $display("test los done");

    pl2_on_stop = 1'b1;
    cyc(1);
    pl2_on_stop = 1'b0;
    expect_within(pl2_active, 1'b1, 100, "level two late");
    expect_now(pl2_timeout, 1'b0, "level two timed out");
    pl2_off_stop = 1'b1;
    cyc(1);
    pl2_off_stop = 1'b0;
    expect_within(pl2_supply_en, 1'b0, 100, "level two supply on");
    expect_within(pl2_active, 1'b0, 100, "level two still active");
    $display("test power level done");
    close_out();
  end
endmodule // optical_module_ctrl_status_bench
